// ---- dv/io_port_monitor.sv ----
// assertions on the port's bus, mode inputs and pin drive
// assumes one clock domain and a one-wait-state bus answer
`timescale 1ns/100ps
module io_port_monitor #(parameter int WIDTH = 8) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [17:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic standby_in,
  input wire logic hold_in,
  input wire logic [7:0] port_pins_out,
  input wire logic [7:0] port_pins_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // completed reads, one per register
  sequence s_dir_rd; avs_read_in && !avs_waitrequest_out && avs_address_in == 18'h3ffac; endsequence
  sequence s_dat_rd; avs_read_in && !avs_waitrequest_out && avs_address_in == 18'h3ff6c; endsequence
  a_dir_reads_ones: assert property (s_dir_rd |-> avs_readdata_out == 32'h000000ff)
    else $error("direction read not all ones");
  a_data_upper_zero: assert property (s_dat_rd |-> avs_readdata_out[31:8] == 24'h000000)
    else $error("data read upper bits set");
  // output pins read back what they drive when hold was off in the prepare cycle
  a_out_reads_drive: assert property (s_dat_rd ##0 !$past(hold_in)
    |-> ((avs_readdata_out[7:0] ^ port_pins_out) & port_pins_oe_out) == 8'h00)
    else $error("output pin read differs from drive");
  a_wait_first: assert property ($rose(avs_read_in) || $rose(avs_write_in) |-> avs_waitrequest_out)
    else $error("no wait in first cycle");
  a_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=>
    !avs_waitrequest_out) else $error("answer late");
  a_standby_float: assert property (standby_in && $past(standby_in) |-> port_pins_oe_out == 8'h00)
    else $error("pin driven in standby");
  a_hold_frozen: assert property ($past(hold_in) |-> $stable(port_pins_out) && $stable(port_pins_oe_out))
    else $error("pins moved in hold");
  a_reset_float: assert property ($rose(reset_n_in) |-> port_pins_oe_out == 8'h00 [*2])
    else $error("pin driven after reset");
endmodule // io_port_monitor
bind io_port io_port_monitor #(.WIDTH(WIDTH)) mon (.clock_in, .reset_n_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .standby_in, .hold_in,
  .port_pins_out, .port_pins_oe_out);

// ---- dv/pin_board.sv ----
// board model: resolves each pin from the port's drive and the board's source
// assumes no pull resistors; an undriven pin follows the board source
`timescale 1ns/100ps
module pin_board (
  input wire logic [7:0] drive_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] ext_in,
  output logic [7:0] level_out
);
  // port wins where it drives, so no contention is modelled
  assign level_out = (drive_in & oe_in) | (ext_in & ~oe_in);
endmodule // pin_board

// ---- dv/tb.sv ----
// self-checking bench: bus tasks, random pin traffic, mode and reset cases
// assumes the one-wait-state bus and the board model on the pins
`timescale 1ns/100ps
module tb;
  logic clock_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, standby_in, hold_in;
  logic [17:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd;
  logic [3:0] avs_byteenable_in;
  logic [7:0] port_pins_in, port_pins_out, port_pins_oe_out, ext, d, dir, p;
  int errors, n_compared, cyc, seed;
  io_port dut (.clock_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .standby_in, .hold_in, .port_pins_in, .port_pins_out, .port_pins_oe_out);
  pin_board board (.drive_in(port_pins_out), .oe_in(port_pins_oe_out), .ext_in(ext),
    .level_out(port_pins_in));
  function logic [31:0] exp_port(input logic [7:0] v, input logic [7:0] m, input logic [7:0] x);
    return {24'h000000, (v & m) | (x & ~m)};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // request held until waitrequest is sampled low at a rising edge; data taken there
  task acc(input logic w, input logic [15:0] ix, input logic [7:0] wd);
    @(posedge clock_in);
    avs_address_in <= {ix, 2'b00};
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_writedata_in <= {24'h000000, wd};
    @(posedge clock_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clock_in);
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock_in) if (++cyc == 20000) begin
    errors++;
    conclude;
  end
  initial begin
    {reset_n_in, avs_read_in, avs_write_in, standby_in, hold_in} = 5'h00;
    avs_address_in = 18'h00000;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'h1;
    ext = 8'h5a;
    seed = 95;
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    acc(1'b0, 16'hffeb, 8'h00);
    chk("dir", rd, 32'h000000ff);
    chk("oe", port_pins_oe_out, 32'h00000000);
    acc(1'b1, 16'hffeb, 8'hff);
    acc(1'b0, 16'hffdb, 8'h00);
    chk("data", rd, 32'h00000000);
    acc(1'b0, 16'h0123, 8'h00);
    chk("unmapped", rd, 32'h00000000);
    // low byte lane off: the write must not land
    avs_byteenable_in <= 4'h0;
    acc(1'b1, 16'hffdb, 8'hff);
    avs_byteenable_in <= 4'h1;
    acc(1'b0, 16'hffdb, 8'h00);
    chk("lane off", rd, 32'h00000000);
    // random data, direction and board levels; corners first
    for (int i = 0; i < 24; i++) begin
      d = i < 2 ? 8'hff : $random(seed);
      dir = i < 2 ? {8{i[0]}} : $random(seed);
      ext <= $random(seed);
      acc(1'b1, 16'hffdb, d);
      acc(1'b1, 16'hffeb, dir);
      repeat (6) @(posedge clock_in);
      acc(1'b0, 16'hffdb, 8'h00);
      chk("port", rd, exp_port(d, dir, ext));
      chk("oe", port_pins_oe_out, dir);
      chk("drive", port_pins_out & dir, d & dir);
    end
    // hold freezes drive though the write lands; standby floats all
    p = port_pins_out;
    hold_in <= 1'b1;
    acc(1'b1, 16'hffdb, ~d);
    repeat (2) @(posedge clock_in);
    chk("hold", port_pins_out, p);
    hold_in <= 1'b0;
    acc(1'b0, 16'hffdb, 8'h00);
    chk("released", port_pins_out & dir, ~d & dir);
    standby_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    chk("standby", port_pins_oe_out, 32'h00000000);
    standby_in <= 1'b0;
    reset_n_in <= 1'b0;
    @(posedge clock_in);
    chk("in reset", port_pins_oe_out, 32'h00000000);
    reset_n_in <= 1'b1;
    // let the pin levels pass the synchroniser before reading them
    repeat (8) @(posedge clock_in);
    acc(1'b0, 16'hffdb, 8'h00);
    chk("reset data", rd, exp_port(8'h00, 8'h00, ext));
    conclude;
  end
endmodule // tb

// ---- logic/io_port.sv ----
// 8-bit general-purpose i/o port with data and direction registers
// assumes an avalon-mm master on clock_in and mode levels from power control
`timescale 1ns/100ps
`include "io_port_consts.svh"

// register map, one 32-bit word per register, byte lane 0 only:
//   port data at word index 0xffdb, byte address 0x3ff6c
//     read/write, clears to zero on reset
//     a read mixes stored bits (output pins) with sampled levels (input pins)
//   port direction at word index 0xffeb, byte address 0x3ffac
//     write-only, reads back as all ones, clears to zero on reset
//     one bit per pin: one drives, zero listens
// every other index reads zero and ignores writes
//
// input pins pass three flops and two level registers before a read sees them,
// so a read reflects a pin change some five to six cycles late; software
// that polls a pin must allow for that latency
//
// the mode inputs come from power control as plain levels on clock_in;
// standby wins over hold when both are high

module io_port #(
  parameter int WIDTH = `PORT_WIDTH
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [`BUS_ADDR_WIDTH-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [`BUS_DATA_WIDTH-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [`BUS_DATA_WIDTH-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic standby_in,
  input wire logic hold_in,
  input wire logic [`PORT_WIDTH-1:0] port_pins_in,
  output logic [`PORT_WIDTH-1:0] port_pins_out,
  output logic [`PORT_WIDTH-1:0] port_pins_oe_out
);

  // the whole port state, registered as one struct
  io_port_pkg::port_state_t state_r;
  io_port_pkg::port_state_t state_nxt;

  // bus decode, shared by the read answer and the register writes
  logic request;
  logic [`BUS_ADDR_WIDTH-`BUS_WORD_LSB-1:0] word_index;
  logic data_hit;
  logic direction_hit;
  logic write_enabled;

  // value a port read returns, built pin by pin
  io_port_pkg::port_byte_t port_read;

  // raw pins out to the synchroniser, accepted levels back
  pin_sample_if pins ();

  // refuse sizes the fixed register map cannot serve
  if (WIDTH != `PORT_WIDTH) begin : g_bad_width
    $error("io_port is built for exactly eight pins");
  end
  if (`BUS_ADDR_WIDTH - `BUS_WORD_LSB != 16) begin : g_bad_index
    $error("io_port needs a 16-bit register index");
  end
  if (`BUS_DATA_WIDTH < `PORT_WIDTH) begin : g_bad_bus
    $error("io_port needs a bus at least one port wide");
  end

  // byte address four times the register index; used for reads and writes
  function automatic logic hits(input logic [`BUS_ADDR_WIDTH-`BUS_WORD_LSB-1:0] idx,
                                input logic [15:0] reg_index);
    hits = (idx == reg_index);
  endfunction

  // three flops per pin; a change counts once the last two agree
  // the raw pin is never read directly, so a pin moving during a read
  // cannot split one answer between two levels
  pin_sync #(
    .STAGES(`SYNC_STAGES)
  ) u_pin_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .pins(pins.sync_side)
  );

  // pins go to the synchroniser untouched
  assign pins.raw = port_pins_in;

  // one request at a time; read and write are never both high
  assign request = avs_read_in | avs_write_in;
  assign word_index = avs_address_in[`BUS_ADDR_WIDTH-1:`BUS_WORD_LSB];
  assign data_hit = hits(word_index, `PORT_DATA_INDEX);
  assign direction_hit = hits(word_index, `PORT_DIRECTION_INDEX);
  // only the low byte lane holds a register
  assign write_enabled = avs_write_in && avs_byteenable_in[0];

  // per-pin read select; inputs read the registered level, not the raw pin
  for (genvar g = 0; g < WIDTH; g++) begin : g_read
    assign port_read[g] = state_r.direction[g] ? state_r.data[g] :
      state_r.pin_level[g];
  end

  // bus timing, one wait state on every access:
  //   first cycle of a request: waitrequest high, read data prepared
  //   second cycle: waitrequest low, read data stands, a write lands at its end
  //   unmapped addresses read zero and drop writes
  //   a write with the low byte lane off changes nothing
  // the extra cycle keeps read data in a flop rather than on a long mux path
  // read data is only replaced by the next read, so it stands after the answer
  always_comb begin
    state_nxt = state_r;
    state_nxt.pin_level = pins.level;
    unique case (state_r.bus_state)
      io_port_pkg::bus_idle_s: begin
        if (request) begin
          state_nxt.bus_state = io_port_pkg::bus_answer_s;
        end
        if (avs_read_in) begin
          state_nxt.readdata = '0; // unmapped reads give zero
          if (data_hit) begin
            state_nxt.readdata[`PORT_WIDTH-1:0] = port_read;
          end
          if (direction_hit) begin
            state_nxt.readdata[`PORT_WIDTH-1:0] = `PORT_DIRECTION_READ;
          end
        end
      end
      io_port_pkg::bus_answer_s: begin
        // write lands on the edge where waitrequest is low
        state_nxt.bus_state = io_port_pkg::bus_idle_s;
        if (write_enabled && data_hit) begin
          state_nxt.data = avs_writedata_in[`PORT_WIDTH-1:0];
        end
        if (write_enabled && direction_hit) begin
          state_nxt.direction = avs_writedata_in[`PORT_WIDTH-1:0];
        end
      end
      default: begin
        // illegal code: back to idle without touching the registers
        state_nxt.bus_state = io_port_pkg::bus_idle_s;
      end
    endcase
    // pin drive by mode:
    //   standby floats every pin whatever the direction says
    //   hold (sleep, subsleep, watch) keeps the last drive and enable
    //   otherwise direction and data pass straight to the pins
    // registers still take writes in hold; the pins catch up when hold drops
    if (standby_in) begin
      state_nxt.pin_enable = '0;
    end else if (!hold_in) begin
      state_nxt.pin_enable = state_nxt.direction;
      state_nxt.pin_value = state_nxt.data;
    end
  end

  // reset floats every pin and clears both registers
  // constants only in the reset branch, so the flops reset cleanly
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r.data <= `PORT_DATA_RESET;
      state_r.direction <= `PORT_DIRECTION_RESET;
      state_r.pin_level <= '0;
      state_r.pin_enable <= '0;
      state_r.pin_value <= `PORT_DATA_RESET;
      state_r.readdata <= '0;
      state_r.bus_state <= io_port_pkg::bus_idle_s;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one wait state on every access; combinational so the first cycle always waits
  assign avs_waitrequest_out = request && (state_r.bus_state == io_port_pkg::bus_idle_s);
  // read data straight from its flop
  assign avs_readdata_out = state_r.readdata;

  // per-pin output stage; an input pin keeps its driver off, except in hold, where the enable stays frozen
  for (genvar g = 0; g < WIDTH; g++) begin : g_drive
    assign port_pins_out[g] = state_r.pin_value[g];
    assign port_pins_oe_out[g] = state_r.pin_enable[g];
  end

endmodule // io_port

// ---- logic/io_port_consts.svh ----
// named offsets, reset values and field layout of the 8-bit i/o port
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

`define PORT_WIDTH 8
`define PORT_DATA_INDEX 16'hffdb
`define PORT_DIRECTION_INDEX 16'hffeb
`define PORT_DATA_RESET 8'h00
`define PORT_DIRECTION_RESET 8'h00
`define PORT_DIRECTION_READ 8'hff
`define BUS_ADDR_WIDTH 18
`define BUS_WORD_LSB 2
`define BUS_DATA_WIDTH 32
`define SYNC_STAGES 3

`endif

// ---- logic/io_port_pkg.sv ----
// types shared by the port top module and its pin synchroniser
// assumes io_port_consts.svh supplies the widths
`include "io_port_consts.svh"

package io_port_pkg;
  typedef logic [`PORT_WIDTH-1:0] port_byte_t;

  // one-wait-state bus answer
  typedef enum logic [1:0] {
    bus_idle_s = 2'b01,
    bus_answer_s = 2'b10
  } bus_state_t;

  typedef struct packed {
    port_byte_t data;
    port_byte_t direction;
    port_byte_t pin_level;
    port_byte_t pin_enable;
    port_byte_t pin_value;
    logic [`BUS_DATA_WIDTH-1:0] readdata;
    bus_state_t bus_state;
  } port_state_t;

  typedef struct packed {
    port_byte_t stage1;
    port_byte_t stage2;
    port_byte_t stage3;
    port_byte_t level;
  } sync_state_t;
endpackage : io_port_pkg

// ---- logic/pin_sample_if.sv ----
// carries raw pin levels into the synchroniser and the accepted level back
// assumes both ends share clock_in
`timescale 1ns/100ps
`include "io_port_consts.svh"

interface pin_sample_if;
  io_port_pkg::port_byte_t raw;
  io_port_pkg::port_byte_t level;

  modport port_side (output raw, input level);
  modport sync_side (input raw, output level);
endinterface : pin_sample_if

// ---- logic/pin_sync.sv ----
// three-stage synchroniser for the port pins with agreement filter
// assumes pin levels arrive asynchronously to clock_in
`timescale 1ns/100ps
`include "io_port_consts.svh"

module pin_sync #(
  parameter int STAGES = `SYNC_STAGES
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  pin_sample_if.sync_side pins
);

  io_port_pkg::sync_state_t state_r;
  io_port_pkg::sync_state_t state_nxt;

  initial begin
    if (STAGES != `SYNC_STAGES) begin
      $error("pin_sync supports exactly three stages");
    end
  end

  // stage1 feeds only stage2; the level moves once stages 2 and 3 agree
  always_comb begin
    state_nxt = state_r;
    state_nxt.stage1 = pins.raw;
    state_nxt.stage2 = state_r.stage1;
    state_nxt.stage3 = state_r.stage2;
    for (int i = 0; i < `PORT_WIDTH; i++) begin
      if (state_r.stage2[i] == state_r.stage3[i]) begin
        state_nxt.level[i] = state_r.stage3[i];
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pins.level = state_r.level;

endmodule // pin_sync
